// [rtl/ssm_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ssm_link_if;
    logic sck;
    logic csN;
    logic mosi;
    logic miso;
    logic misoOeN;

    modport master (output sck, output csN, output mosi,
                    input miso, input misoOeN);
    modport slave (input sck, input csN, input mosi,
                   output miso, output misoOeN);
endinterface : ssm_link_if
`default_nettype wire

// [rtl/ssm_master.sv]
`timescale 1ns/1ps
`default_nettype none
module ssm_master
    import ssm_pkg::*;
#(
    parameter int HALF_CYCLES = SCK_HALF_CYCLES
)(
    // System
    input wire logic clk,
    input wire logic rst_n,
    // Link
    ssm_link_if.master link,
    // Command
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic [2:0] cmdPage,
    input wire logic cmdWrite,
    input wire logic [7:0] cmdAddr,
    input wire logic [7:0] cmdData,
    // Response from the frame just finished
    output logic rspValid,
    output logic [23:0] rspFrame
);

    typedef enum logic [1:0] {IDLE, SETUP, SHIFT, DONE} ssm_mstate_e;
    ssm_mstate_e state_reg;
    logic [15:0] divCnt_reg;
    logic [4:0] bitCnt_reg;
    logic [FRAME_BITS-1:0] txShift_reg;
    logic [FRAME_BITS-1:0] rxShift_reg;
    logic sck_reg;
    logic divTick;
    assign divTick = divCnt_reg == 16'(HALF_CYCLES - 1);
    assign cmdReady = state_reg == IDLE;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= IDLE;
            divCnt_reg <= 16'h0000;
            bitCnt_reg <= 5'h00;
            txShift_reg <= '0;
            rxShift_reg <= '0;
            sck_reg <= 1'b0;
            rspValid <= 1'b0;
            rspFrame <= '0;
        end else begin
            rspValid <= 1'b0;
            divCnt_reg <= divTick ? 16'h0000 : divCnt_reg + 16'h0001;
            case (state_reg)
                IDLE: begin
                    divCnt_reg <= 16'h0000;
                    if (cmdValid) begin
                        // Reads send address bit 13 as zero.
                        txShift_reg <= {cmdPage,
                            cmdWrite ? cmdAddr : {cmdAddr[7:1], 1'b0},
                            cmdWrite, cmdData, 4'h0};
                        bitCnt_reg <= 5'h00;
                        state_reg <= SETUP;
                    end
                end
                SETUP: if (divTick) state_reg <= SHIFT;
                SHIFT: if (divTick) begin
                    sck_reg <= !sck_reg;
                    // The first bit already stands from setup, so only the
                    // later rises move the next bit out.
                    if (!sck_reg && bitCnt_reg != 5'h00)
                        txShift_reg <= {txShift_reg[FRAME_BITS-2:0],
                                        1'b0};
                    if (sck_reg) begin
                        // A released data line reads as the inverse of the
                        // slave's last bit, so it can never look valid.
                        rxShift_reg <= {rxShift_reg[FRAME_BITS-2:0],
                                        link.miso ^ link.misoOeN};
                        bitCnt_reg <= bitCnt_reg + 5'h01;
                        if (bitCnt_reg == 5'(FRAME_BITS - 1))
                            state_reg <= DONE;
                    end
                end
                DONE: if (divTick) begin
                    rspValid <= 1'b1;
                    rspFrame <= rxShift_reg;
                    state_reg <= IDLE;
                end
                default: state_reg <= IDLE;
            endcase
        end
    end

    // New bit is presented when the clock goes up; the slave samples low.
    assign link.sck = sck_reg;
    assign link.mosi = txShift_reg[FRAME_BITS-1];
    assign link.csN = state_reg == IDLE;

endmodule : ssm_master
`default_nettype wire

// [rtl/ssm_pkg.sv]
package ssm_pkg;

    // ************************************************************
    // Frame layout
    // ************************************************************
    localparam int FRAME_BITS = 24;
    localparam int PAGE_MSB = 23;
    localparam int PAGE_LSB = 21;
    localparam int ADDR_MSB = 20;
    localparam int ADDR_LSB = 13;
    localparam int DIR_BIT = 12;
    localparam int DATA_MSB = 11;
    localparam int DATA_LSB = 4;

    // ************************************************************
    // Page codes
    // ************************************************************
    localparam logic [2:0] PAGE_TEST = 3'h0;
    localparam logic [2:0] PAGE_DATA_RAM = 3'h1;
    localparam logic [2:0] PAGE_CSR2 = 3'h2;
    localparam logic [2:0] PAGE_DEV_RAM = 3'h3;
    localparam logic [2:0] PAGE_OTP = 3'h4;
    localparam logic [2:0] PAGE_EEPROM = 3'h5;
    localparam logic [2:0] PAGE_RSVD = 3'h6;
    localparam logic [2:0] PAGE_CSR7 = 3'h7;

    // ************************************************************
    // Response header and memory address width
    // ************************************************************
    localparam logic [7:0] RESP_HEADER = 8'h05;
    localparam int MEM_ADDR_BITS = 12;
    localparam logic [3:0] PAGE_REG_RESET = 4'h0;

    // ************************************************************
    // Master serial clock: half period in system clock cycles
    // ************************************************************
    localparam int SCK_HALF_NS = 250;
    localparam int CLK_NS = 25;
    localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;

endpackage : ssm_pkg

// [rtl/ssm_slave.sv]
`timescale 1ns/1ps
`default_nettype none
module ssm_slave
    import ssm_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic rst_n,
    // Link
    ssm_link_if.slave link,
    // Control bits
    input wire logic serialEnable,
    input wire logic interfaceSelect,
    input wire logic [1:0] dataRamPage,
    input wire logic [3:0] devRamPage,
    input wire logic [3:0] otpPage,
    // Memory access
    output logic memReq,
    output logic memWrite,
    output logic [2:0] memPage,
    output logic [MEM_ADDR_BITS-1:0] memAddr,
    output logic [7:0] memWdata,
    input wire logic [15:0] memRdata,
    input wire logic memAck,
    // Status
    output logic frameDropped
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [2:0] sckSync;
    logic [2:0] csSync;
    logic [2:0] mosiSync;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sckSync <= 3'h0;
            csSync <= 3'h7;
            mosiSync <= 3'h0;
        end else begin
            sckSync <= {sckSync[1:0], link.sck};
            csSync <= {csSync[1:0], link.csN};
            mosiSync <= {mosiSync[1:0], link.mosi};
        end
    end

    logic sckLvl_reg;
    logic csLvl_reg;
    logic mosiLvl_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sckLvl_reg <= 1'b0;
            csLvl_reg <= 1'b1;
            mosiLvl_reg <= 1'b0;
        end else begin
            if (sckSync[1] == sckSync[2]) sckLvl_reg <= sckSync[2];
            if (csSync[1] == csSync[2]) csLvl_reg <= csSync[2];
            if (mosiSync[1] == mosiSync[2]) mosiLvl_reg <= mosiSync[2];
        end
    end

    // Filtered-level edges; sampling on the master's falling edge keeps
    // us half a period away from where it launches on rising.
    logic sckQual;
    logic csQual;
    assign sckQual = (sckSync[1] == sckSync[2]) ? sckSync[2] : sckLvl_reg;
    assign csQual = (csSync[1] == csSync[2]) ? csSync[2] : csLvl_reg;
    logic sckRise;
    logic sckFall;
    logic csRise;
    assign sckRise = sckQual && !sckLvl_reg;
    assign sckFall = !sckQual && sckLvl_reg;
    assign csRise = csQual && !csLvl_reg;

    logic portActive;
    assign portActive = serialEnable && !csLvl_reg;

    // ************************************************************
    // Shift in
    // ************************************************************
    logic [FRAME_BITS-1:0] shiftIn_reg;
    logic [4:0] bitCnt_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shiftIn_reg <= '0;
            bitCnt_reg <= 5'h00;
        end else if (!portActive) begin
            bitCnt_reg <= 5'h00;
        end else if (sckFall) begin
            shiftIn_reg <= {shiftIn_reg[FRAME_BITS-2:0], mosiLvl_reg};
            // Saturating above a full frame makes long frames fail too.
            if (bitCnt_reg != 5'h1f) bitCnt_reg <= bitCnt_reg + 5'h01;
        end
    end

    // A frame is acted on at select rise only if exactly 24 bits came in.
    logic frameDone;
    assign frameDone = csRise && serialEnable
                       && bitCnt_reg == 5'(FRAME_BITS);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frameDropped <= 1'b0;
        end else begin
            frameDropped <= csRise && serialEnable
                            && bitCnt_reg != 5'(FRAME_BITS)
                            && bitCnt_reg != 5'h00;
        end
    end

    // ************************************************************
    // Decode
    // ************************************************************
    function automatic logic [MEM_ADDR_BITS-1:0] buildAddr(
        input logic [2:0] page, input logic [7:0] low,
        input logic [1:0] dPg, input logic [3:0] vPg, input logic [3:0] oPg);
        case (page)
            PAGE_DATA_RAM: buildAddr = {2'h0, dPg, low};
            PAGE_DEV_RAM: buildAddr = {vPg, low};
            PAGE_OTP: buildAddr = {oPg, low};
            default: buildAddr = {4'h0, low};
        endcase
    endfunction : buildAddr

    logic [2:0] fPage;
    logic [7:0] fAddr;
    logic fWrite;
    logic [7:0] fData;
    assign fPage = shiftIn_reg[PAGE_MSB:PAGE_LSB];
    assign fAddr = shiftIn_reg[ADDR_MSB:ADDR_LSB];
    assign fWrite = shiftIn_reg[DIR_BIT];
    assign fData = shiftIn_reg[DATA_MSB:DATA_LSB];

    logic pageAllowed;
    assign pageAllowed = (fPage != PAGE_RSVD)
                         && (interfaceSelect || fPage == PAGE_TEST);

    // ************************************************************
    // Memory request
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            memReq <= 1'b0;
            memWrite <= 1'b0;
            memPage <= PAGE_TEST;
            memAddr <= '0;
            memWdata <= 8'h00;
        end else if (frameDone && pageAllowed) begin
            memReq <= 1'b1;
            memWrite <= fWrite;
            memPage <= fPage;
            memWdata <= fData;
            memAddr <= buildAddr(fPage,
                fWrite ? fAddr : {fAddr[7:1], 1'b0},
                dataRamPage, devRamPage, otpPage);
        end else if (memAck) begin
            memReq <= 1'b0;
        end
    end

    // Read data held until the next frame shifts it out.
    logic [15:0] readHold_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readHold_reg <= 16'h0000;
        end else if (memReq && memAck && !memWrite) begin
            readHold_reg <= memRdata;
        end
    end

    // ************************************************************
    // Shift out
    // ************************************************************
    logic [FRAME_BITS-1:0] shiftOut_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shiftOut_reg <= '0;
        end else if (!portActive) begin
            shiftOut_reg <= {RESP_HEADER, readHold_reg};
        end else if (sckRise && bitCnt_reg != 5'h00) begin
            shiftOut_reg <= {shiftOut_reg[FRAME_BITS-2:0], 1'b0};
        end
    end

    assign link.miso = shiftOut_reg[FRAME_BITS-1];
    assign link.misoOeN = !portActive;

endmodule : ssm_slave
`default_nettype wire

// [tb/ssm_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module ssm_monitor (
    // System
    input wire logic clk,
    input wire logic rst_n,
    // Link
    input wire logic sck,
    input wire logic csN,
    input wire logic mosi,
    input wire logic miso,
    input wire logic misoOeN
);
    // ****
    // Serial clock rises seen in the current frame
    // ****
    logic sckPrev_reg;
    logic [5:0] edgeCount_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sckPrev_reg <= 1'b0;
        end else begin
            sckPrev_reg <= sck;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edgeCount_reg <= 6'h0;
        end else if (csN) begin
            edgeCount_reg <= 6'h0;
        end else if (sck && !sckPrev_reg) begin
            edgeCount_reg <= edgeCount_reg + 6'h1;
        end
    end

    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sck_idle_a: assert property (csN |-> !sck)
        else $error("serial clock active while deselected");
    select_lead_a: assert property ($fell(csN) |-> !sck [*4])
        else $error("serial clock too soon after select");
    select_trail_a: assert property ($rose(csN) |-> !sck)
        else $error("select released with clock high");
    frame_length_a: assert property ($rose(csN) |-> edgeCount_reg == 6'h18)
        else $error("frame without exactly 24 clocks");
    miso_release_a: assert property (csN [*8] |-> misoOeN)
        else $error("data output driven while deselected");
    miso_hold_a: assert property (!sck && !$past(sck) && !misoOeN
        |-> $stable(miso))
        else $error("data output changed while clock low");
    mosi_hold_a: assert property (sck && $past(sck) |-> $stable(mosi))
        else $error("data input changed while clock high");
    sck_pulse_a: assert property ($rose(sck) |-> ##[1:40] !sck)
        else $error("serial clock stuck high");
endmodule : ssm_monitor
`default_nettype wire

// [tb/tb_spi_slave_memory_access.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_spi_slave_memory_access
    import ssm_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, cmdValid = 1'b0, cmdWrite = 1'b0;
    logic [2:0] cmdPage = 3'h0, memPage;
    logic [7:0] cmdAddr = 8'h0, cmdData = 8'h0, memWdata;
    logic serialEnable = 1'b0, interfaceSelect = 1'b0, memAck = 1'b0;
    logic [1:0] dataRamPage = 2'h0;
    logic [3:0] devRamPage = 4'h0, otpPage = 4'h0;
    logic [15:0] memRdata = 16'h0;
    logic cmdReady, rspValid, memReq, memWrite, frameDropped, sckWas = 1'b0;
    logic [23:0] rspFrame, mosiSh, misoSh, pendRsp, m;
    logic [MEM_ADDR_BITS-1:0] memAddr;
    logic [44:0] r;
    logic pend = 1'b0;
    logic [23:0] expMem[$];
    logic [44:0] expRsp[$];
    int miscompares = 0;
    int samplesChecked = 0;

    always #12.5 clk = ~clk;

    ssm_link_if link();
    ssm_master #(.HALF_CYCLES(6)) ssm_master_i(.clk, .rst_n, .link(link),
        .cmdValid, .cmdReady, .cmdPage, .cmdWrite, .cmdAddr, .cmdData,
        .rspValid, .rspFrame);
    ssm_slave ssm_slave_i(.clk, .rst_n, .link(link), .serialEnable,
        .interfaceSelect, .dataRamPage, .devRamPage, .otpPage, .memReq,
        .memWrite, .memPage, .memAddr, .memWdata, .memRdata, .memAck,
        .frameDropped);
    ssm_monitor ssm_monitor_i(.clk, .rst_n, .sck(link.sck), .csN(link.csN),
        .mosi(link.mosi), .miso(link.miso), .misoOeN(link.misoOeN));

    // Memory contents are a pattern of the address, so no array is needed.
    function automatic logic [7:0] pat(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'h9};
    endfunction : pat

    task automatic check(input string what, input logic [23:0] exp,
                         input logic [23:0] got);
        samplesChecked++;
        if (exp !== got) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic results();
        check("requests left", 24'h0, 24'(expMem.size()));
        $display("checked %0d miscompares %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    // ****
    // Command driver and expectations
    // ****
    task automatic send(input logic [2:0] pg, input logic wr,
                        input logic [7:0] ad);
        logic [7:0] dt;
        logic [9:0] pr;
        logic [11:0] ma;
        logic ok;
        int n;
        dt = 8'($urandom);
        pr = 10'($urandom);
        if (!wr) ad[0] = 1'b0;
        @(posedge clk);
        {dataRamPage, devRamPage, otpPage} <= pr;
        case (pg)
            PAGE_DATA_RAM: ma = {2'h0, pr[9:8], ad};
            PAGE_DEV_RAM: ma = {pr[7:4], ad};
            PAGE_OTP: ma = {pr[3:0], ad};
            default: ma = {4'h0, ad};
        endcase
        ok = serialEnable && pg != PAGE_RSVD
            && (interfaceSelect || pg == PAGE_TEST);
        if (ok) expMem.push_back({wr, pg, ma, wr ? dt : 8'h00});
        expRsp.push_back({pend, pendRsp, pg, ad, wr, dt});
        pend = ok && !wr;
        pendRsp = {RESP_HEADER, pat(ma), pat(ma | 12'h1)};
        cmdValid <= 1'b1;
        {cmdPage, cmdWrite, cmdAddr, cmdData} <= {pg, wr, ad, dt};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (cmdReady !== 1'b1 && n < 100);
        check("command taken", 24'h1, {23'h0, cmdReady});
        cmdValid <= 1'b0;
        for (n = 0; rspValid !== 1'b1 && n < 2000; n++) @(posedge clk);
        check("response seen", 24'h1, {23'h0, rspValid});
        // Page registers may only move once the slave has used them.
        for (n = 0; expMem.size() > 0 && n < 60; n++) @(posedge clk);
    endtask : send

    // ****
    // Memory responder and output watcher
    // ****
    always @(posedge clk) begin
        sckWas <= link.sck;
        memAck <= memReq === 1'b1 && memAck === 1'b0 && $urandom_range(1);
        memRdata <= {pat(memAddr), pat(memAddr | 12'h1)};
        if (!link.csN && sckWas && !link.sck) begin
            mosiSh <= {mosiSh[22:0], link.mosi};
            misoSh <= {misoSh[22:0], link.miso};
        end
        if (memReq === 1'b1 && memAck === 1'b1) begin
            m = expMem.size() ? expMem.pop_front() : 24'hxx_xxxx;
            check("request", m, {memWrite, memPage, memAddr,
                  memWrite ? memWdata : 8'h00});
        end
        if (rspValid === 1'b1 && expRsp.size()) begin
            r = expRsp.pop_front();
            check("mosi frame", {4'h0, r[19:0]}, {4'h0, mosiSh[23:4]});
            if (r[44]) check("response", r[43:20], rspFrame);
            if (r[44]) check("miso frame", r[43:20], misoSh);
        end
        if (frameDropped === 1'b1) check("drop", 24'h0, 24'h1);
    end

    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        results();
    end

    initial begin
        void'($urandom(32'hab8f_d956));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        send(PAGE_CSR2, 1'b1, 8'h30);
        serialEnable <= 1'b1;
        send(PAGE_CSR2, 1'b1, 8'h19);
        send(PAGE_TEST, 1'b0, 8'h05);
        send(PAGE_TEST, 1'b1, 8'hff);
        interfaceSelect <= 1'b1;
        for (int k = 0; k < 24; k++) begin
            send(3'(k), k >= 8 && k < 16, 8'($urandom));
        end
        send(PAGE_TEST, 1'b1, 8'h00);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        pend = 1'b0;
        send(PAGE_DEV_RAM, 1'b0, 8'h65);
        send(PAGE_EEPROM, 1'b0, 8'h07);
        send(PAGE_TEST, 1'b1, 8'h00);
        results();
    end
endmodule : tb_spi_slave_memory_access
`default_nettype wire
